// [core/hpa_commit.sv]
`default_nettype none
module hpa_commit
  import hpa_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic por, // power-on reset, drops pending data
  input wire logic ce, // clock enable
  input wire logic start, // one cached write to commit
  output logic busy // media write in progress
);
  // ------------------------------------------------------------
  // media commit timer
  // ------------------------------------------------------------
  logic [7:0] cnt; // cycles left on current commit
  logic [7:0] pend; // writes queued behind current one
  // soft reset and comreset do not reach this: only power-on
  always_ff @(posedge clk_sys)
  begin
    if (por)
    begin
      cnt <= 8'h00; // power loss ends the write at once
      pend <= 8'h00;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
      end
      else if (pend != 8'h00)
      begin
        cnt <= 8'(COMMIT_CYC);
        pend <= pend - 8'h01 + {7'h00, start};
      end
      else if (start)
      begin
        cnt <= 8'(COMMIT_CYC);
      end
      if (cnt != 8'h00 && start)
      begin
        pend <= pend + 8'h01;
      end
      busy <= (cnt > 8'h01) || (pend != 8'h00) || start;
    end
  end
endmodule // hpa_commit
`default_nettype wire

// [core/hpa_core.sv]
// ------------------------------------------------------------
// Summary of operation
// - read native max returns true native LBA
// - identify capacity follows new maximum
// - volatile setting dropped on link reset, nonvolatile kept
// - sectors above maximum refused
// - password sector: words 1-16 hold password
// - set password stores it, enters unlocked
// - lock rejects all but unlock, freeze
// - unlock compares password, aborts on mismatch
// - lock loads five tries, mismatch decrements
// - zero tries: every unlock aborted
// - freeze rejects all set-max commands
// - password, state, tries survive soft resets
// - set max after read native is address
// - cached write completes once data buffered
// - soft resets never cut a media commit
// - flush, reset, standby, sleep wait commit
// ------------------------------------------------------------
`default_nettype none
module hpa_core
  import hpa_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // power-on reset, high
  input wire logic link_rst, // comreset or software reset
  input wire logic ce, // clock enable
  input wire logic wc_en, // write cache enabled
  input wire logic cmd_valid, // command strobe
  input wire logic [7:0] cmd_op, // command opcode
  input wire logic [7:0] cmd_feat, // feature field
  input wire logic [27:0] cmd_lba, // lba field
  input wire logic cmd_nv, // nonvolatile option
  input wire logic dat_valid, // data word strobe
  input wire logic [15:0] dat_word, // data word
  input wire logic dat_last, // last word of command data
  output logic done, // answer pulse
  output logic [1:0] status, // answer status code
  output logic [27:0] ret_lba, // returned lba
  output logic [27:0] id_max, // capacity for identify
  output logic [1:0] sec_state, // security state
  output logic [2:0] tries, // unlock attempts left
  output logic media_busy, // cached data not yet on media
  output logic ready // able to take a command
);
  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PW_DATA = 3'b001,
    ST_UL_DATA = 3'b010,
    ST_WR_DATA = 3'b011,
    ST_DRAIN = 3'b100,
    ST_CMP = 3'b101
  } hpa_st_e;
  hpa_st_e st; // command sequencer state
  hpa_sec_e sec; // set-max security state
  logic [27:0] max_vol; // maximum in force
  logic [27:0] max_nv; // nonvolatile maximum
  logic last_native; // previous command was read native
  logic [7:0] widx; // word index within data sector
  logic mismatch; // any password word differed
  logic [3:0] cmp_idx; // compare word index
  logic cmp_run; // compare in progress
  logic cmp_last; // last store word in flight
  logic [7:0] pend_op; // opcode waiting on drain
  logic wr_start; // one cached write handed to commit
  logic commit_busy; // commit engine busy
  hpa_pw_if pw (); // password store port

  hpa_pw_mem u_mem (.clk_sys(clk_sys), .ce(ce), .pw(pw));
  hpa_commit u_commit (.clk_sys(clk_sys), .por(rst), .ce(ce),
    .start(wr_start), .busy(commit_busy));

  // ------------------------------------------------------------
  // password port steering
  // ------------------------------------------------------------
  logic in_pw; // word lies in password range
  assign in_pw = (widx >= PW_FIRST) && (widx <= PW_LAST);
  assign pw.wr = (st == ST_PW_DATA) && dat_valid && in_pw;
  assign pw.wdata = dat_word;
  assign pw.idx = (st == ST_CMP) ? cmp_idx
    : 4'(widx - PW_FIRST);

  // unlock words buffered for compare against the store
  logic [15:0] ul_buf [PW_WORDS]; // received unlock words
  for (genvar i = 0; i < PW_WORDS; i++)
  begin : g_ulbuf
    always_ff @(posedge clk_sys)
    begin
      if (ce && st == ST_UL_DATA && dat_valid && in_pw
          && 4'(widx - PW_FIRST) == 4'(i))
      begin
        ul_buf[i] <= dat_word;
      end
    end
  end

  // decoded set-max subcommand, address forced after read native
  logic [7:0] sub; // effective subcommand
  assign sub = last_native ? SUB_ADDRESS : cmd_feat;
  logic sm_ok; // subcommand allowed in current state
  always_comb
  begin
    sm_ok = 1'b1;
    unique case (sec)
      SEC_IDLE, SEC_UNLOCKED: sm_ok = (sub != SUB_UNLOCK);
      SEC_LOCKED: sm_ok = (sub == SUB_UNLOCK)
        || (sub == SUB_FREEZE) && !last_native;
      SEC_FROZEN: sm_ok = 1'b0;
    endcase
  end
  logic is_wr; // a cacheable write command
  assign is_wr = (cmd_op == OP_WRITE_SECT) || (cmd_op == OP_WRITE_MULT);
  logic is_sync; // command that must wait for media
  assign is_sync = (cmd_op == OP_FLUSH) || (cmd_op == OP_STANDBY)
    || (cmd_op == OP_STANDBY_IMM) || (cmd_op == OP_SLEEP)
    || (cmd_op == OP_SOFT_RESET);
  logic take; // command accepted this cycle
  assign take = ce && cmd_valid && st == ST_IDLE;

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  // link resets return the sequencer to idle but leave security
  always_ff @(posedge clk_sys)
  begin
    if (rst || link_rst)
    begin
      st <= ST_IDLE;
      widx <= 8'h00;
      pend_op <= 8'h00;
      cmp_idx <= 4'h0;
      cmp_run <= 1'b0;
      cmp_last <= 1'b0;
      mismatch <= 1'b0;
    end
    else if (ce)
    begin
      unique case (st)
        ST_IDLE:
        begin
          widx <= 8'h00;
          if (take && cmd_op == OP_SET_MAX && sm_ok)
          begin
            if (sub == SUB_PASSWORD)
            begin
              st <= ST_PW_DATA;
            end
            else if (sub == SUB_UNLOCK && tries != 3'h0)
            begin
              st <= ST_UL_DATA;
            end
          end
          else if (take && is_wr && wc_en)
          begin
            st <= ST_WR_DATA;
          end
          else if (take && is_sync && wc_en)
          begin
            st <= ST_DRAIN;
            pend_op <= cmd_op;
          end
        end
        ST_PW_DATA, ST_WR_DATA:
        begin
          if (dat_valid)
          begin
            widx <= widx + 8'h01;
            if (dat_last)
            begin
              st <= ST_IDLE;
            end
          end
        end
        ST_UL_DATA:
        begin
          if (dat_valid)
          begin
            widx <= widx + 8'h01;
            if (dat_last)
            begin
              st <= ST_CMP;
              cmp_idx <= 4'h0;
              cmp_run <= 1'b0;
              cmp_last <= 1'b0;
              mismatch <= 1'b0;
            end
          end
        end
        ST_CMP:
        begin
          // store read data lags its index by one cycle
          cmp_run <= 1'b1;
          if (cmp_run && !cmp_last)
          begin
            mismatch <= mismatch
              | (pw.rdata != ul_buf[4'(cmp_idx - 4'h1)]);
          end
          if (cmp_idx != 4'hf)
          begin
            cmp_idx <= cmp_idx + 4'h1;
          end
          else if (!cmp_last)
          begin
            cmp_last <= 1'b1; // word 15 still on its way out
          end
          else
          begin
            st <= ST_IDLE;
          end
        end
        ST_DRAIN:
        begin
          if (!commit_busy)
          begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // final compare result including the last word
  logic cmp_fail; // password mismatch seen
  assign cmp_fail = mismatch | (pw.rdata != ul_buf[4'hf]);
  logic cmp_end; // compare finishes this cycle
  assign cmp_end = st == ST_CMP && cmp_last;

  // ------------------------------------------------------------
  // security machine, tries and maximum address
  // ------------------------------------------------------------
  // only power-on clears these; link resets leave them
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sec <= SEC_IDLE;
      tries <= 3'h0;
    end
    else if (ce)
    begin
      if (st == ST_PW_DATA && dat_valid && dat_last)
      begin
        sec <= SEC_UNLOCKED;
      end
      else if (take && cmd_op == OP_SET_MAX && sm_ok)
      begin
        if (sub == SUB_LOCK)
        begin
          sec <= SEC_LOCKED;
          tries <= UNLOCK_TRIES;
        end
        else if (sub == SUB_FREEZE)
        begin
          sec <= SEC_FROZEN;
        end
      end
      else if (cmp_end)
      begin
        if (cmp_fail)
        begin
          tries <= tries - 3'h1;
        end
        else
        begin
          sec <= SEC_UNLOCKED;
        end
      end
    end
  end

  // volatile maximum falls back to nonvolatile on link reset, to native on power-on
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      max_vol <= NATIVE_MAX;
      max_nv <= NATIVE_MAX;
      last_native <= 1'b0;
    end
    else if (link_rst)
    begin
      max_vol <= max_nv;
      last_native <= 1'b0;
    end
    else if (ce && take)
    begin
      last_native <= (cmd_op == OP_READ_NATIVE);
      if (cmd_op == OP_SET_MAX && sm_ok && sub == SUB_ADDRESS
          && cmd_lba <= NATIVE_MAX)
      begin
        max_vol <= cmd_lba;
        if (cmd_nv)
        begin
          max_nv <= cmd_lba;
        end
      end
    end
  end
  // nonvolatile copy would sit on media; power-on keeps the native
  // default here, a real drive reloads it from its reserved area

  // ------------------------------------------------------------
  // answers
  // ------------------------------------------------------------
  assign wr_start = ce && st == ST_WR_DATA && dat_valid && dat_last;
  always_ff @(posedge clk_sys)
  begin
    if (rst || link_rst)
    begin
      done <= 1'b0;
      status <= ST_OK;
      ret_lba <= 28'h0000000;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (take && cmd_op == OP_READ_NATIVE)
      begin
        done <= 1'b1;
        status <= ST_OK;
        ret_lba <= NATIVE_MAX;
      end
      else if (take && cmd_op == OP_SET_MAX)
      begin
        if (!sm_ok || (sub == SUB_UNLOCK && tries == 3'h0))
        begin
          done <= 1'b1;
          status <= ST_ABORT;
        end
        else if (sub != SUB_PASSWORD && sub != SUB_UNLOCK)
        begin
          done <= 1'b1;
          status <= (sub == SUB_ADDRESS && cmd_lba > NATIVE_MAX)
            ? ST_ABORT : ST_OK;
        end
      end
      else if (take && (is_wr || is_sync) && !wc_en)
      begin
        done <= 1'b1;
        status <= (is_wr && cmd_lba > max_vol) ? ST_RANGE : ST_OK;
      end
      else if (take && is_wr && cmd_lba > max_vol)
      begin
        status <= ST_RANGE;
      end
      else if (take && !is_wr && !is_sync)
      begin
        done <= 1'b1; // other commands end at once
        status <= (cmd_lba > max_vol) ? ST_RANGE : ST_OK;
      end
      else if (st == ST_PW_DATA && dat_valid && dat_last)
      begin
        done <= 1'b1;
        status <= ST_OK;
      end
      else if (st == ST_WR_DATA && dat_valid && dat_last)
      begin
        done <= 1'b1; // buffered data completes the write
      end
      else if (cmp_end)
      begin
        done <= 1'b1;
        status <= cmp_fail ? ST_ABORT : ST_OK;
      end
      else if (st == ST_DRAIN && !commit_busy)
      begin
        done <= 1'b1; // completion confirms write-back
        status <= ST_OK;
      end
    end
  end

  // status mirrors for identify and the outside
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      id_max <= NATIVE_MAX;
      sec_state <= 2'h0;
      media_busy <= 1'b0;
      ready <= 1'b0;
    end
    else if (ce)
    begin
      id_max <= max_vol;
      sec_state <= sec;
      media_busy <= commit_busy;
      ready <= (st == ST_IDLE) && !take;
    end
  end
endmodule // hpa_core
`default_nettype wire

// [core/hpa_pkg.sv]
`default_nettype none
package hpa_pkg;
  // command opcodes
  localparam logic [7:0] OP_READ_NATIVE = 8'hf8;
  localparam logic [7:0] OP_SET_MAX = 8'hf9;
  localparam logic [7:0] OP_WRITE_SECT = 8'h30;
  localparam logic [7:0] OP_WRITE_MULT = 8'hc5;
  localparam logic [7:0] OP_FLUSH = 8'he7;
  localparam logic [7:0] OP_STANDBY = 8'he2;
  localparam logic [7:0] OP_STANDBY_IMM = 8'he0;
  localparam logic [7:0] OP_SLEEP = 8'he6;
  localparam logic [7:0] OP_SOFT_RESET = 8'h08;
  // set-max subcommand codes in the feature field
  localparam logic [7:0] SUB_ADDRESS = 8'h00;
  localparam logic [7:0] SUB_PASSWORD = 8'h01;
  localparam logic [7:0] SUB_LOCK = 8'h02;
  localparam logic [7:0] SUB_UNLOCK = 8'h03;
  localparam logic [7:0] SUB_FREEZE = 8'h04;
  // address and password geometry
  localparam int LBA_W = 28;
  localparam logic [27:0] NATIVE_MAX = 28'h00fffff;
  localparam int PW_WORDS = 16;
  localparam int SECT_WORDS = 256;
  localparam logic [7:0] PW_FIRST = 8'h01;
  localparam logic [7:0] PW_LAST = 8'h10;
  localparam logic [2:0] UNLOCK_TRIES = 3'h5;
  // answer status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_ABORT = 2'h1;
  localparam logic [1:0] ST_RANGE = 2'h2;
  // media commit time per cached write
  localparam int COMMIT_NS = 200;
  localparam int CLK_NS = 20;
  localparam int COMMIT_CYC = (COMMIT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    SEC_IDLE = 2'b00,
    SEC_UNLOCKED = 2'b01,
    SEC_LOCKED = 2'b10,
    SEC_FROZEN = 2'b11
  } hpa_sec_e;
endpackage
`default_nettype wire

// [core/hpa_pw_if.sv]
`default_nettype none
// password word stream from the top into the store
interface hpa_pw_if;
  logic wr; // password word write strobe
  logic [3:0] idx; // password word index 0..15
  logic [15:0] wdata; // incoming word
  logic [15:0] rdata; // stored word at idx, registered
  modport top (output wr, output idx, output wdata, input rdata);
  modport mem (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// [core/hpa_pw_mem.sv]
`default_nettype none
module hpa_pw_mem
  import hpa_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic ce, // clock enable
  hpa_pw_if.mem pw // password access port
);
  // ------------------------------------------------------------
  // password store: kept across every reset, power-on included
  // ------------------------------------------------------------
  logic [15:0] mem [PW_WORDS]; // sixteen password words
  // no reset on purpose: only power loss clears the password
  always_ff @(posedge clk_sys)
  begin
    if (ce && pw.wr)
    begin
      mem[pw.idx] <= pw.wdata;
    end
  end
  // registered read for compare
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      pw.rdata <= mem[pw.idx];
    end
  end
endmodule // hpa_pw_mem
`default_nettype wire

// [sim/hpa_core_props.sv]
`default_nettype none
module hpa_core_props
  import hpa_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // power-on reset
  input wire logic link_rst, // link or soft reset
  input wire logic ce, // clock enable
  input wire logic wc_en, // write cache on
  input wire logic cmd_valid, // command strobe
  input wire logic [7:0] cmd_op, // opcode
  input wire logic [7:0] cmd_feat, // feature
  input wire logic [27:0] cmd_lba, // lba
  input wire logic dat_valid, // data strobe
  input wire logic dat_last, // last data word
  input wire logic done, // answer pulse
  input wire logic [1:0] status, // answer code
  input wire logic [27:0] ret_lba, // returned lba
  input wire logic [27:0] id_max, // capacity
  input wire logic [1:0] sec_state, // lock state
  input wire logic [2:0] tries, // tries left
  input wire logic media_busy, // commit running
  input wire logic ready // idle
);
  timeunit 1ns;
  timeprecision 100ps;
  logic take; // command accepted at this edge
  logic [7:0] last_op; // newest accepted opcode
  logic [7:0] prev_op; // opcode before that
  logic [27:0] last_lba; // lba of newest command
  assign take = cmd_valid && ce && ready;
  // history survives link reset, unlike the command sequencer, which link reset returns to idle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      last_op <= 8'h00;
      prev_op <= 8'h00;
    end
    else if (take)
    begin
      prev_op <= last_op;
      last_op <= cmd_op;
      last_lba <= cmd_lba;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_NATIVE_MAX: assert property (
    take && cmd_op == OP_READ_NATIVE && !link_rst |=>
    done && status == ST_OK && ret_lba == NATIVE_MAX)
    else $error("native max answer wrong");
  AST_NEW_MAX: assert property (
    done && status == ST_OK && last_op == OP_SET_MAX &&
    prev_op == OP_READ_NATIVE |=> id_max == last_lba)
    else $error("identify capacity not updated");
  AST_LOCK_LOAD: assert property (
    $changed(sec_state) && sec_state == SEC_LOCKED |->
    tries == UNLOCK_TRIES)
    else $error("tries not loaded on lock");
  AST_TRIES_STEP: assert property (
    !$past(rst) && tries < $past(tries) |->
    tries == $past(tries) - 3'h1)
    else $error("tries dropped by more than one");
  AST_FROZEN_STAYS: assert property (
    sec_state == SEC_FROZEN |=> sec_state == SEC_FROZEN)
    else $error("frozen state left");
  AST_LINK_KEEPS: assert property (
    link_rst |=> $stable(sec_state) && $stable(tries))
    else $error("link reset touched security");
  AST_ZERO_TRIES: assert property (
    take && cmd_op == OP_SET_MAX && cmd_feat == SUB_UNLOCK &&
    last_op != OP_READ_NATIVE && tries == 3'h0 |->
    ##[1:600] (done && status == ST_ABORT))
    else $error("unlock with no tries not aborted");
  AST_FROZEN_ABORT: assert property (
    take && cmd_op == OP_SET_MAX && last_op != OP_READ_NATIVE &&
    sec_state == SEC_FROZEN |-> ##[1:600] (done && status == ST_ABORT))
    else $error("set max taken while frozen");
  AST_WRITE_EARLY: assert property (
    dat_valid && dat_last && ce && wc_en && !ready &&
    (last_op == OP_WRITE_SECT || last_op == OP_WRITE_MULT) |=> done)
    else $error("cached write answer late");
  AST_DRAIN: assert property (
    done && (last_op == OP_FLUSH || last_op == OP_STANDBY ||
    last_op == OP_STANDBY_IMM || last_op == OP_SLEEP ||
    last_op == OP_SOFT_RESET) |-> !media_busy)
    else $error("drain answered before commit");
  AST_COMMIT_HOLD: assert property (
    $rose(media_busy) |-> media_busy [*8])
    else $error("media commit cut short");
  cover property (done && status == ST_ABORT && sec_state == SEC_LOCKED);
  cover property (sec_state == SEC_FROZEN);
  cover property (link_rst && media_busy);
endmodule // hpa_core_props
bind hpa_core hpa_core_props i_hpa_core_props (.clk_sys, .rst,
  .link_rst, .ce, .wc_en, .cmd_valid, .cmd_op, .cmd_feat, .cmd_lba,
  .dat_valid, .dat_last, .done, .status, .ret_lba, .id_max,
  .sec_state, .tries, .media_busy, .ready);
`default_nettype wire

// [sim/hpa_host.sv]
`default_nettype none
module hpa_host
  import hpa_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic ready, // device idle
  input wire logic done, // answer pulse
  input wire logic [1:0] status, // answer code
  output logic cmd_valid, // command strobe
  output logic [7:0] cmd_op, // opcode
  output logic [7:0] cmd_feat, // feature
  output logic [27:0] cmd_lba, // lba
  output logic cmd_nv, // nonvolatile option
  output logic dat_valid, // data strobe
  output logic [15:0] dat_word, // data word
  output logic dat_last // last word
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_feat = 8'h00;
    cmd_lba = 28'h0000000;
    cmd_nv = 1'b0;
    dat_valid = 1'b0;
    dat_word = 16'h0000;
    dat_last = 1'b0;
  end
  // one command, optional sector, answer; one at a time, waits done
  task automatic run(input logic [7:0] op, input logic [7:0] feat,
    input logic [27:0] lba, input logic nv, input logic data,
    input logic [15:0] key, output logic [1:0] st);
    int n;
    logic got; // device answered during the data phase
    n = 0;
    got = 1'b0;
    @(posedge clk_sys);
    while (!ready && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_feat <= feat;
    cmd_lba <= lba;
    cmd_nv <= nv;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (int i = 0; i < SECT_WORDS && data && !got; i++)
    begin
      dat_valid <= 1'b1;
      // words 1..16 carry the password, the rest is filler
      dat_word <= (i >= 1 && i <= 16) ? key + 16'(i) : ~16'(i);
      dat_last <= (i == SECT_WORDS - 1);
      @(posedge clk_sys);
      got = done; // refused at once: stop sending the sector
    end
    dat_valid <= 1'b0;
    dat_last <= 1'b0;
    dat_word <= ~dat_word; // stale data never looks valid
    n = 0;
    while (!got && !done && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    st = status;
  endtask
endmodule // hpa_host
`default_nettype wire

// [sim/testbench.sv]
`default_nettype none
module testbench;
  import hpa_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, link_rst, ce, wc_en, cmd_valid, cmd_nv;
  logic dat_valid, dat_last, done, media_busy, ready;
  logic [7:0] cmd_op, cmd_feat;
  logic [27:0] cmd_lba, ret_lba, id_max, lba_a, lba_b;
  logic [15:0] dat_word, key;
  logic [1:0] status, sec_state, st;
  logic [2:0] tries, t;
  int num_errors = 0;
  int n_compared = 0;
  integer seed = 41;
  hpa_core i_hpa_core (.clk_sys, .rst, .link_rst, .ce, .wc_en,
    .cmd_valid, .cmd_op, .cmd_feat, .cmd_lba, .cmd_nv, .dat_valid,
    .dat_word, .dat_last, .done, .status, .ret_lba, .id_max,
    .sec_state, .tries, .media_busy, .ready);
  hpa_host i_hpa_host (.clk_sys, .ready, .done, .status, .cmd_valid,
    .cmd_op, .cmd_feat, .cmd_lba, .cmd_nv, .dat_valid, .dat_word,
    .dat_last);
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [27:0] seen,
    input logic [27:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // expected unlock answer: only a match with tries left succeeds
  function automatic logic [1:0] unlock_st(input logic [2:0] n,
    input logic hit);
    return (hit && n != 3'h0) ? ST_OK : ST_ABORT;
  endfunction
  function automatic logic [2:0] after_miss(input logic [2:0] n);
    return (n == 3'h0) ? 3'h0 : n - 3'h1;
  endfunction
  task automatic go(input logic [7:0] op, input logic [7:0] feat,
    input logic [27:0] lba, input logic nv, input logic data,
    input logic [15:0] k);
    i_hpa_host.run(op, feat, lba, nv, data, k, st);
    #1; // let the mirrors settle before anything is compared
  endtask
  task automatic power(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic pulse_link();
    @(posedge clk_sys);
    link_rst <= 1'b1;
    @(posedge clk_sys);
    link_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  initial
  begin
    #1_000_000;
    num_errors++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    link_rst = 1'b0;
    ce = 1'b1;
    wc_en = 1'b1;
    power(20);
    lba_a = NATIVE_MAX - 28'($random(seed) & 32'h3ffff);
    lba_b = NATIVE_MAX - 28'($random(seed) & 32'h0ffff);
    key = 16'($random(seed));
    // --------------------------------------
    // maximum address handling
    // --------------------------------------
    go(OP_READ_NATIVE, SUB_ADDRESS, 28'h0, 1'b0, 1'b0, key);
    check("native", ret_lba, NATIVE_MAX);
    go(OP_SET_MAX, SUB_ADDRESS, lba_a, 1'b1, 1'b0, key);
    check("max nv", id_max, lba_a);
    go(OP_READ_NATIVE, SUB_ADDRESS, 28'h0, 1'b0, 1'b0, key);
    check("native2", ret_lba, NATIVE_MAX);
    go(OP_SET_MAX, 8'($random(seed)), lba_b, 1'b0, 1'b0, key);
    check("max vol", id_max, lba_b);
    pulse_link();
    check("max back", id_max, lba_a);
    // --------------------------------------
    // cached writes and draining commands
    // --------------------------------------
    for (int k = 0; k < 5; k++)
    begin
      go(k[0] ? OP_WRITE_MULT : OP_WRITE_SECT, 8'h00,
        28'($random(seed) & 32'hfffff) % lba_a, 1'b0, 1'b1, key);
      check("wr st", st, ST_OK);
      check("wr busy", media_busy, 1'b1);
      if (k == 0)
        pulse_link();
      if (k == 0)
        check("busy link", media_busy, 1'b1);
      go(k == 0 ? OP_FLUSH : k == 1 ? OP_STANDBY : k == 2 ?
        OP_STANDBY_IMM : k == 3 ? OP_SLEEP : OP_SOFT_RESET,
        8'h00, 28'h0, 1'b0, 1'b0, key);
      check("drain busy", media_busy, 1'b0);
    end
    // uncached: answers at once, range still checked
    wc_en <= 1'b0;
    go(OP_WRITE_SECT, 8'h00, lba_a + 28'h1, 1'b0, 1'b0, key);
    check("range st", st, ST_RANGE);
    go(OP_FLUSH, 8'h00, 28'h0, 1'b0, 1'b0, key);
    check("nc flush", st, ST_OK);
    wc_en <= 1'b1;
    // --------------------------------------
    // password, lock and unlock counting
    // --------------------------------------
    go(OP_SET_MAX, SUB_PASSWORD, 28'h0, 1'b0, 1'b1, key);
    check("pw state", sec_state, SEC_UNLOCKED);
    go(OP_SET_MAX, SUB_LOCK, 28'h0, 1'b0, 1'b0, key);
    check("lock state", sec_state, SEC_LOCKED);
    check("lock tries", tries, UNLOCK_TRIES);
    for (int k = 0; k < 3; k++)
    begin
      go(OP_SET_MAX, k == 2 ? SUB_LOCK : 8'(k), NATIVE_MAX, 1'b1,
        k == 1, key);
      check("lock st", st, ST_ABORT);
      check("lock max", id_max, lba_a);
    end
    go(OP_SET_MAX, SUB_UNLOCK, 28'h0, 1'b0, 1'b1, key ^ 16'h0001);
    check("miss st", st, ST_ABORT);
    check("miss tries", tries, 3'h4);
    pulse_link();
    check("link state", sec_state, SEC_LOCKED);
    check("link tries", tries, 3'h4);
    go(OP_SET_MAX, SUB_UNLOCK, 28'h0, 1'b0, 1'b1, key);
    check("hit state", sec_state, SEC_UNLOCKED);
    go(OP_SET_MAX, SUB_LOCK, 28'h0, 1'b0, 1'b0, key);
    t = UNLOCK_TRIES;
    for (int k = 0; k < 6; k++)
    begin
      go(OP_SET_MAX, SUB_UNLOCK, 28'h0, 1'b0, 1'b1, ~key);
      check("miss n st", st, unlock_st(t, 1'b0));
      t = after_miss(t);
      check("miss n tries", tries, t);
    end
    go(OP_SET_MAX, SUB_UNLOCK, 28'h0, 1'b0, 1'b1, key);
    check("spent st", st, unlock_st(t, 1'b1));
    check("spent state", sec_state, SEC_LOCKED);
    // --------------------------------------
    // freeze, then a power cycle clears state and tries
    // --------------------------------------
    go(OP_SET_MAX, SUB_FREEZE, 28'h0, 1'b0, 1'b0, key);
    check("frz state", sec_state, SEC_FROZEN);
    go(OP_SET_MAX, SUB_UNLOCK, 28'h0, 1'b0, 1'b1, key);
    check("frz unlock", st, ST_ABORT);
    go(OP_SET_MAX, SUB_ADDRESS, NATIVE_MAX, 1'b1, 1'b0, key);
    check("frz addr", st, ST_ABORT);
    check("frz max", id_max, lba_a);
    power(4);
    check("por state", sec_state, SEC_IDLE);
    check("por tries", tries, 3'h0);
    close_out();
  end
endmodule // testbench
`default_nettype wire
